// ### hdl/bcie_bit_counter.sv
// Transfer bit counter: loads a 3-bit setting and counts bits down.
// Assumes bit_done_i is a one-cycle pulse per serial bit, same clock.
`timescale 1ns/1ps
`include "bcie_defines.svh"
module bcie_bit_counter
  import bcie_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       clk_en_i,
  // Load from software and bit progress.
  input  wire logic       load_i,
  input  wire logic [2:0] load_val_i,
  input  wire logic       bit_done_i,
  // Field readback: bits still to transfer, in field encoding.
  output logic      [2:0] remain_o
);
  logic [2:0] count_r;   // Field-encoded remaining count.
  logic [2:0] setting_r; // Reload value for the next transfer.
  logic [2:0] count_nxt; // Next count.

  // ============================================================
  // Count down; code 000 stands for the full length, so after the
  // last bit the field wraps back to the software setting.
  assign count_nxt = load_i ? load_val_i :
                     (count_r == 3'h1) ? setting_r :
                     3'(count_r - 3'h1);

  // Counter registers; load wins over a bit in the same cycle.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r   <= `BCIE_BC_RST;
      setting_r <= `BCIE_BC_RST;
    end else if (clk_en_i && (load_i || bit_done_i)) begin
      count_r <= count_nxt;
      if (load_i) begin
        setting_r <= load_val_i;
      end
    end
  end

  assign remain_o = count_r; // [R3]
endmodule

// ### hdl/bcie_irq_gate.sv
// Interrupt request gating: each request is flag AND enable; overrun also needs the clocked format.
// Assumes flags come from same-clock flag logic.
`timescale 1ns/1ps
module bcie_irq_gate
  import bcie_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  // Sources.
  input  wire bcie_flags_t flags_i,
  input  wire logic        tie_i,
  input  wire logic        tx_end_irq_enable_i,
  input  wire logic        rie_i,
  input  wire bcie_fmt_t   fmt_i,
  // Requests, registered.
  output bcie_irqs_t       irqs_o
);
  bcie_irqs_t irqs_nxt; // Combined requests.

  // ============================================================
  // Overrun passes only in the clocked format; the two-wire format gates it out.
  assign irqs_nxt.tx_empty_irq = flags_i.tx_empty_flag & tie_i; // [R4]
  assign irqs_nxt.tx_end_irq   = flags_i.tx_end_flag & tx_end_irq_enable_i; // [R5] [R6]
  assign irqs_nxt.rx_full_irq  = flags_i.rx_full_flag & rie_i; // [R7] [R9]
  assign irqs_nxt.overrun_irq  = flags_i.overrun_flag & rie_i &
                                 (fmt_i == BCIE_FMT_CLOCKED); // [R8]

  // Update every cycle so a cleared flag withdraws next cycle.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irqs_o <= '0;
    end else if (clk_en_i) begin
      irqs_o <= irqs_nxt; // [R13]
    end
  end
endmodule

// ### hdl/bcie_top.sv
// Bit counter and interrupt enable registers of the two-wire interface.
// Assumes a classic Wishbone master and same-clock flag logic.
//
// Overview of operation
// [R1] Two-wire: 000 is nine, else plus one.
// [R2] Clocked: 000 is eight, else as written.
// [R3] Counter read returns bits still remaining.
// [R4] Transmit-empty request is flag AND enable.
// [R5] Transmit-end raised at ninth clock rising edge.
// [R6] Transmit-end withdrawn when flag or enable clears.
// [R7] Receive-full request on data moving to register.
// [R8] Receive enable gates overrun, clocked format only.
// [R9] Receive-full withdrawn when flag or enable clears.
// [R10] Enables and counter bits reset to zero.
// [R11] Counter written only with write-protect zero.
// [R12] Transmit-empty set on move to shift register.
// [R13] Requests are AND levels, updated every cycle.
`timescale 1ns/1ps
`include "bcie_defines.svh"
module bcie_top
  import bcie_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Engine side.
  input  wire bcie_fmt_t   fmt_i,
  input  wire logic        bit_done_i,
  input  wire logic        scl_rise_i,
  input  wire logic [3:0]  scl_count_i,
  input  wire logic        tx_load_shift_i,
  input  wire bcie_flags_t flags_i,
  // Decoded transfer length and flag event.
  output logic      [3:0]  bits_per_xfer_o,
  output logic             tx_empty_set_o,
  output logic             tx_end_set_o,
  // Interrupt requests.
  output bcie_irqs_t       irqs_o,
  output logic             irq_o
);
  // ============================================================
  // Register storage.
  logic [7:0] mode_r;     // Format-independent mode bits.
  logic [7:0] ien_r;      // Interrupt enable register.
  logic [3:0] stat_r;     // Sticky interrupt status.
  logic [3:0] mask_r;     // Interrupt mask.
  logic       ack_r;      // Wishbone acknowledge.
  logic [31:0] rdat_r;    // Registered read data.
  logic [2:0] remain;     // Remaining bit count from the counter.
  bcie_irqs_t irqs;       // Gated requests.
  bcie_flags_t flags_g;   // Flags passed to the gate unchanged.

  // ============================================================
  // Address decode; a request is answered once, one cycle later.
  // A request is taken once: a pending ack or err blocks a second take,
  // so err stays a one-cycle pulse even while the master still holds.
  wire req       = wb_cyc_i & wb_stb_i & ~ack_r & ~wb_err_o;
  // A write lands at the edge where the master samples ack high.
  wire done      = wb_cyc_i & wb_stb_i & ack_r;
  wire hit_mode  = wb_adr_i == `BCIE_OFS_MODE;
  wire hit_ien   = wb_adr_i == `BCIE_OFS_IEN;
  wire hit_stat  = wb_adr_i == `BCIE_OFS_IRQ_STAT;
  wire hit_mask  = wb_adr_i == `BCIE_OFS_IRQ_MASK;
  wire mapped    = hit_mode | hit_ien | hit_stat | hit_mask;
  wire wr_lane0  = done & wb_we_i & wb_sel_i[0] & clk_en_i;
  wire wr_mode   = wr_lane0 & hit_mode;
  wire wr_ien    = wr_lane0 & hit_ien;
  wire wr_stat   = wr_lane0 & hit_stat;
  wire wr_mask   = wr_lane0 & hit_mask;
  // The counter only takes a write whose protect bit is zero.
  wire bc_load   = wr_mode & ~wb_dat_i[`BCIE_MODE_BIT_COUNT_WRITE_PROTECT]; // [R11]

  // ============================================================
  // Decode the field into a bit count per format.
  wire [3:0] two_wire_bits = (remain == 3'h0) ? 4'h9 :
                             4'({1'b0, remain} + 4'h1); // [R1]
  wire [3:0] clocked_bits  = (remain == 3'h0) ? 4'h8 :
                             {1'b0, remain}; // [R2]
  assign bits_per_xfer_o = (fmt_i == BCIE_FMT_CLOCKED) ?
                           clocked_bits : two_wire_bits;

  // Transmit-empty is set when the data register is moved on.
  assign tx_empty_set_o = tx_load_shift_i; // [R12]
  // Transmit-end event at the ninth rising edge while still empty.
  assign tx_end_set_o = scl_rise_i & flags_i.tx_empty_flag &
                        (scl_count_i == `BCIE_NINTH_CLK); // [R5]

  // Transmit-end requests only exist once the flag logic has set it.
  always_comb begin
    flags_g = flags_i;
  end

  // ============================================================
  // Counter and request gating.
  bcie_bit_counter u_counter (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .clk_en_i   (clk_en_i),
    .load_i     (bc_load),
    .load_val_i (wb_dat_i[2:0]),
    .bit_done_i (bit_done_i),
    .remain_o   (remain)
  );

  bcie_irq_gate u_gate (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .clk_en_i  (clk_en_i),
    .flags_i   (flags_g),
    .tie_i     (ien_r[`BCIE_IEN_TIE]),
    .tx_end_irq_enable_i    (ien_r[`BCIE_IEN_TX_END_IRQ_ENABLE]),
    .rie_i     (ien_r[`BCIE_IEN_RIE]),
    .fmt_i     (fmt_i),
    .irqs_o    (irqs)
  );
  assign irqs_o = irqs;

  // ============================================================
  // Mode and enable registers; enables reset to zero.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= `BCIE_MODE_RST;
      ien_r  <= `BCIE_IEN_RST; // [R10]
    end else begin
      if (wr_mode) begin
        mode_r <= {wb_dat_i[7:6], 2'b11, wb_dat_i[3], 3'h0};
      end
      if (wr_ien) begin
        ien_r <= wb_dat_i[7:0];
      end
    end
  end

  // Sticky status; a new event wins over a write-one clear.
  wire [3:0] ev = {irqs.tx_empty_irq, irqs.tx_end_irq,
                   irqs.rx_full_irq, irqs.overrun_irq};
  wire [3:0] clr = wr_stat ? wb_dat_i[3:0] : 4'h0;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_r <= 4'h0;
      mask_r <= 4'h0;
    end else if (clk_en_i) begin
      stat_r <= (stat_r & ~clr) | ev;
      if (wr_mask) begin
        mask_r <= wb_dat_i[3:0];
      end
    end
  end
  assign irq_o = |(stat_r & mask_r);

  // ============================================================
  // Read mux: counter field reads remaining bits; protect reads 1.
  wire [7:0] mode_rd = {mode_r[7:4], 1'b1, remain}; // [R3]
  wire [31:0] rd_mux = hit_mode ? {24'h0, mode_rd} :
                       hit_ien  ? {24'h0, ien_r} :
                       hit_stat ? {28'h0, stat_r} :
                       hit_mask ? {28'h0, mask_r} : 32'h0;

  // Acknowledge, error and read data, one cycle after the request.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r    <= 1'b0;
      wb_err_o <= 1'b0;
      rdat_r   <= 32'h0;
    end else if (clk_en_i) begin
      ack_r    <= req & mapped;
      wb_err_o <= req & ~mapped;
      rdat_r   <= rd_mux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
endmodule

// ### pkg/bcie_defines.svh
// Constants for the bit counter and interrupt enable block.
// Assumes inclusion by bare name from design and testbench files.
`ifndef BCIE_DEFINES_SVH
`define BCIE_DEFINES_SVH
// ============================================================
// Register offsets (byte addresses on the Wishbone slave).
`define BCIE_OFS_MODE     4'h0
`define BCIE_OFS_IEN      4'h4
`define BCIE_OFS_IRQ_STAT 4'h8
`define BCIE_OFS_IRQ_MASK 4'hc
// ============================================================
// Field positions.
`define BCIE_MODE_BIT_COUNT_WRITE_PROTECT    3
`define BCIE_IEN_TIE      7
`define BCIE_IEN_TX_END_IRQ_ENABLE     6
`define BCIE_IEN_RIE      5
// ============================================================
// Reset values.
`define BCIE_MODE_RST     8'h38
`define BCIE_IEN_RST      8'h00
`define BCIE_BC_RST       3'h0
// ============================================================
// Timing: the ninth serial clock edge of a two-wire byte.
`define BCIE_NINTH_CLK    4'h9
`endif

// ### pkg/bcie_pkg.sv
// Types shared by the bit counter and interrupt enable block.
// Assumes the defines header sits on the include path.
package bcie_pkg;
  // ============================================================
  // Serial format selection.
  typedef enum logic {BCIE_FMT_TWO_WIRE, BCIE_FMT_CLOCKED} bcie_fmt_t;
  // Status flags coming from the flag logic and shift engine.
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_end_flag;
    logic rx_full_flag;
    logic overrun_flag;
  } bcie_flags_t;
  // Interrupt request lines toward the interrupt controller.
  typedef struct packed {
    logic tx_empty_irq;
    logic tx_end_irq;
    logic rx_full_irq;
    logic overrun_irq;
  } bcie_irqs_t;
endpackage

// ### tb/bcie_assertions.sv
// Checker for the bit counter and interrupt enable block.
// Assumes binding to bcie_top; it sees only the top module's ports.
`timescale 1ns/1ps
`include "bcie_defines.svh"
module bcie_assertions
  import bcie_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Engine side and results.
  input wire bcie_fmt_t   fmt_i,
  input wire logic        scl_rise_i,
  input wire logic [3:0]  scl_count_i,
  input wire logic        tx_load_shift_i,
  input wire bcie_flags_t flags_i,
  input wire logic [3:0]  bits_per_xfer_o,
  input wire logic        tx_empty_set_o,
  input wire logic        tx_end_set_o,
  input wire bcie_irqs_t  irqs_o
);
  // ============================================================
  // Enable shadow, taken when a write to the enable register ends.
  // Requests use the enables one cycle late, hence $past on it below.
  logic [2:0] en_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      en_r <= 3'h0;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0]
             && wb_adr_i == `BCIE_OFS_IEN)
      en_r <= wb_dat_i[7:5];
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ============================================================
  // Requests are registered flag AND enable; overrun also needs the clocked format.
  txe_irq_a: assert property (
    irqs_o.tx_empty_irq == ($past(flags_i.tx_empty_flag) & $past(en_r[2])))
    else $error("tx empty request wrong");
  tx_end_flag_irq_a: assert property (
    irqs_o.tx_end_irq == ($past(flags_i.tx_end_flag) & $past(en_r[1])))
    else $error("tx end request wrong");
  rxf_irq_a: assert property (
    irqs_o.rx_full_irq == ($past(flags_i.rx_full_flag) & $past(en_r[0])))
    else $error("rx full request wrong");
  ovr_irq_a: assert property (
    irqs_o.overrun_irq == ($past(flags_i.overrun_flag) & $past(en_r[0])
    & ($past(fmt_i) == BCIE_FMT_CLOCKED)))
    else $error("overrun request wrong");
  txe_set_a: assert property (tx_load_shift_i |-> tx_empty_set_o)
    else $error("tx empty set missed");
  tx_end_flag_set_a: assert property (
    tx_end_set_o |-> scl_rise_i && flags_i.tx_empty_flag
    && scl_count_i == `BCIE_NINTH_CLK) else $error("tx end set wrong");
  bits_two_a: assert property (
    fmt_i == BCIE_FMT_TWO_WIRE |-> bits_per_xfer_o inside {[2:9]})
    else $error("two-wire length out of range");
  bits_clk_a: assert property (
    fmt_i == BCIE_FMT_CLOCKED |-> bits_per_xfer_o inside {[1:8]})
    else $error("clocked length out of range");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  cover property (irqs_o.tx_end_irq);
  cover property (irqs_o.overrun_irq);
  cover property (tx_end_set_o);
endmodule
bind bcie_top bcie_assertions chk_u (
  .sys_clk_i, .resetn_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .fmt_i, .scl_rise_i, .scl_count_i, .tx_load_shift_i,
  .flags_i, .bits_per_xfer_o, .tx_empty_set_o, .tx_end_set_o, .irqs_o);

// ### tb/bcie_partner.sv
// Far-side engine model: serial clock steps, bit progress, flags.
// Assumes the bench pulses step_i and supplies the flag pattern.
`timescale 1ns/1ps
module bcie_partner
  import bcie_pkg::*;
(
  // Clock, reset and commands.
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        step_i,
  input  wire bcie_flags_t flg_i,
  // Engine signals toward the block.
  output logic             bit_done_o,
  output logic             scl_rise_o,
  output logic [3:0]       scl_count_o,
  output logic             tx_load_o,
  output bcie_flags_t      flags_o
);
  // Each step is one serial clock rise; the ninth closes a byte.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {bit_done_o, scl_rise_o, tx_load_o} <= 3'h0;
      scl_count_o <= 4'h0;
      flags_o <= '0;
    end else begin
      {bit_done_o, scl_rise_o} <= {2{step_i}};
      tx_load_o <= step_i && scl_count_o == 4'h8;
      if (step_i)
        scl_count_o <= (scl_count_o >= 4'h9) ? 4'h1 : scl_count_o + 4'h1;
      flags_o <= flg_i;
    end
  end
endmodule

// ### tb/bcie_top_bench.sv
// Self-checking bench for the bit counter and interrupt enable block.
// Assumes the checker is bound to bcie_top by its own file.
`timescale 1ns/1ps
`include "bcie_defines.svh"
module bcie_top_bench;
  import bcie_pkg::*;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic we = 1'b0, step = 1'b0, ack, err, bd, sr, tl, ts, te, irq;
  logic [3:0] adr = 4'h0, scnt, bits;
  logic [31:0] wdat = 32'h0, rdat;
  bcie_fmt_t fmt = BCIE_FMT_TWO_WIRE;
  bcie_flags_t flg = '0, flags;
  bcie_irqs_t irqs;
  logic [64:0] exp_q[$]; // Entries are {err, mask, value}.
  int n_mismatch = 0, comparisons = 0, cycles = 0, seed = 32'h0d4ee17e;
  always #10 sys_clk_i = ~sys_clk_i;
  bcie_top dut_u (.sys_clk_i, .resetn_i, .clk_en_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .fmt_i(fmt), .bit_done_i(bd), .scl_rise_i(sr),
    .scl_count_i(scnt), .tx_load_shift_i(tl), .flags_i(flags),
    .bits_per_xfer_o(bits), .tx_empty_set_o(ts), .tx_end_set_o(te),
    .irqs_o(irqs), .irq_o(irq));
  bcie_partner partner_u (.sys_clk_i, .resetn_i, .step_i(step),
    .flg_i(flg), .bit_done_o(bd), .scl_rise_o(sr), .scl_count_o(scnt),
    .tx_load_o(tl), .flags_o(flags));
  task automatic chk(input string nm, input logic [32:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Classic cycle: hold everything until the answering edge.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, input logic [64:0] e);
    exp_q.push_back(e);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
    do @(posedge sys_clk_i); while (!(ack || err));
    {cyc, stb} <= 2'b00;
    @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 65'h0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] v);
    bus(1'b0, a, 8'h0, {33'h0ffffffff, 24'h0, v});
  endtask
  task automatic stp();
    step <= 1'b1;
    @(posedge sys_clk_i);
    step <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // Monitor: each answer is compared with the oldest note.
  always @(posedge sys_clk_i) begin
    logic [64:0] e;
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      stop_test();
    end
    if (ack || err) begin
      e = exp_q.pop_front();
      chk("bus", {e[64], e[31:0]}, {err, rdat & e[63:32]});
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(`BCIE_OFS_MODE, 8'h38);
    rd(`BCIE_OFS_IEN, 8'h00);
    bus(1'b0, 4'h2, 8'h0, {1'b1, 64'h0});
    for (int f = 0; f < 2; f++) begin
      fmt <= bcie_fmt_t'(f);
      for (int c = 0; c < 8; c++) begin
        wr(`BCIE_OFS_MODE, 8'(c));
        rd(`BCIE_OFS_MODE, 8'h38 | 8'(c));
        chk("bits", 33'((c == 0) ? 9 - f : c + 1 - f), 33'(bits));
      end
    end
    wr(`BCIE_OFS_MODE, 8'hca);
    rd(`BCIE_OFS_MODE, 8'hff);
    wr(`BCIE_OFS_MODE, 8'h03);
    fmt <= BCIE_FMT_TWO_WIRE;
    stp();
    rd(`BCIE_OFS_MODE, 8'h3a);
    wr(`BCIE_OFS_IRQ_MASK, 8'h0f);
    flg <= 4'hf;
    repeat (4) @(posedge sys_clk_i);
    rd(`BCIE_OFS_IRQ_STAT, 8'h00);
    wr(`BCIE_OFS_IEN, 8'he0);
    fmt <= BCIE_FMT_CLOCKED;
    repeat (4) @(posedge sys_clk_i);
    rd(`BCIE_OFS_IRQ_STAT, 8'h0f);
    chk("irq", 33'h1, 33'(irq));
    flg <= 4'h0;
    // Let the requests fall first: a live request wins over the clear.
    repeat (3) @(posedge sys_clk_i);
    wr(`BCIE_OFS_IRQ_STAT, 8'h0f);
    rd(`BCIE_OFS_IRQ_STAT, 8'h00);
    chk("irqs", 33'h0, 33'(irqs));
    wr(`BCIE_OFS_IRQ_MASK, 8'h00);
    fmt <= BCIE_FMT_TWO_WIRE;
    flg <= 4'h3;
    repeat (4) @(posedge sys_clk_i);
    rd(`BCIE_OFS_IRQ_STAT, 8'h02);
    chk("irq", 33'h0, 33'(irq));
    // Random soak: the checker judges every request level.
    repeat (80) begin
      flg <= 4'($random(seed));
      fmt <= bcie_fmt_t'($random(seed) & 1);
      if ($random(seed) & 1) stp();
      else wr(`BCIE_OFS_IEN, 8'($random(seed)));
    end
    stop_test();
  end
endmodule
